// ### design/ecd_pkg.sv
// constants and types shared by the six channel embedded clock deserializer
package ecd_pkg;

  // ---------------------------------------------------------------
  // channel structure
  // ---------------------------------------------------------------
  localparam int NUM_CH         = 6;   // independent channels
  localparam int SER_IN         = 7;   // six channel inputs plus the spare
  localparam int WORD_W         = 10;  // payload bits per frame
  localparam int FRAME_BITS     = 12;  // start + ten data + stop
  localparam int SYNC_FRAMES    = 80;  // good frames needed before lock
  localparam int MISS_LIMIT     = 2;   // consecutive missed edges that drop lock
  localparam int REF_LOCK_EDGES = 16;  // reference edges for the local loop to settle
  localparam int STROBE_HIGH    = 6;   // bit slots the word strobe stays high

  // ---------------------------------------------------------------
  // register map, byte addresses on the control bus
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;

  // control fields
  localparam int          SPARE_SEL_LSB   = 0;
  localparam logic [2:0]  SPARE_SEL_RESET = 3'h6;
  localparam logic [2:0]  SPARE_SEL_OFF   = 3'h6;  // monitor tri-stated
  localparam logic [2:0]  SPARE_SEL_RAW   = 3'h7;  // spare input shown raw

  // status fields
  localparam int STATUS_LOCK_LSB  = 0;
  localparam int STATUS_AWAKE_BIT = 8;
  localparam int STATUS_REF_BIT   = 9;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel alignment states
  typedef enum logic [0:0] {ECD_HUNT, ECD_LOCKED} ecd_state_t;

endpackage

// ### design/ecd_sender_sync_request_b.sv
// two flip-flop synchronizer for pin inputs
`timescale 1ns/10ps
module ecd_sender_sync_request_b #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_reg;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      q          <= '0;
    end else begin
      stage1_reg <= d;
      q          <= stage1_reg;
    end
  end

endmodule

// ### design/ecd_channel.sv
// one deserializer channel: frame hunt, lock tracking and word extraction
`timescale 1ns/10ps
module ecd_channel
  import ecd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              run,
  input  wire logic              bit_strobe,
  input  wire logic              serial_bit,
  output logic      [WORD_W-1:0] word_reg,
  output logic                   locked_reg,
  output logic                   strobe_reg
);

  ecd_state_t       state_reg;
  logic [11:0]      shift_reg;
  logic [3:0]       bit_cnt_reg;
  logic [6:0]       good_cnt_reg;
  logic [1:0]       miss_cnt_reg;
  logic [11:0]      window;
  logic             frame_end;
  logic             frame_ok;
  logic [WORD_W-1:0] data_next;

  // the twelve most recent bits including the one arriving now
  assign window    = {shift_reg[10:0], serial_bit};
  assign frame_end = bit_strobe && (bit_cnt_reg == 4'(FRAME_BITS - 1));
  assign frame_ok  = window[11] & ~window[0];

  // first data bit after the start bit lands on bit 0
  always_comb begin
    data_next = '0;
    for (int i = 0; i < WORD_W; i++) begin
      data_next[i] = window[10 - i];
    end
  end

  // shift register and bit position; a failed hunt slips one bit
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      shift_reg   <= 12'h000;
      bit_cnt_reg <= 4'h0;
    end else if (bit_strobe) begin
      shift_reg <= window;
      if (frame_end) begin
        if (state_reg == ECD_HUNT && !frame_ok) begin
          bit_cnt_reg <= bit_cnt_reg;
        end else begin
          bit_cnt_reg <= 4'h0;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // lock state, good frame and missed edge counters
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      state_reg    <= ECD_HUNT;
      good_cnt_reg <= 7'h00;
      miss_cnt_reg <= 2'h0;
    end else if (frame_end) begin
      unique case (state_reg)
        ECD_HUNT: begin
          if (!frame_ok) begin
            good_cnt_reg <= 7'h00;
          end else if (good_cnt_reg == 7'(SYNC_FRAMES - 1)) begin
            state_reg    <= ECD_LOCKED;
            good_cnt_reg <= 7'h00;
            miss_cnt_reg <= 2'h0;
          end else begin
            good_cnt_reg <= good_cnt_reg + 7'h01;
          end
        end
        ECD_LOCKED: begin
          if (frame_ok) begin
            miss_cnt_reg <= 2'h0;
          end else if (miss_cnt_reg == 2'(MISS_LIMIT - 1)) begin
            state_reg    <= ECD_HUNT;
            miss_cnt_reg <= 2'h0;
          end else begin
            miss_cnt_reg <= miss_cnt_reg + 2'h1;
          end
        end
      endcase
    end
  end

  // word, lock and strobe load together on a good frame; strobe later falls alone and a lock drop keeps the word
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      word_reg   <= '0;
      locked_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else if (frame_end) begin
      if (frame_ok && (state_reg == ECD_LOCKED || good_cnt_reg == 7'(SYNC_FRAMES - 1))) begin
        word_reg   <= data_next;
        locked_reg <= 1'b1;
        strobe_reg <= 1'b1;
      end else if (state_reg == ECD_LOCKED && !frame_ok && miss_cnt_reg == 2'(MISS_LIMIT - 1)) begin
        locked_reg <= 1'b0;
        strobe_reg <= 1'b0;
      end
    end else if (bit_strobe && bit_cnt_reg == 4'(STROBE_HIGH - 1)) begin
      strobe_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lock_after_train: assert property ($rose(locked_reg) |-> $past(good_cnt_reg) == 7'(SYNC_FRAMES - 1))
    else $error("lock taken before eighty good frames");
  a_drop_on_misses: assert property ($fell(locked_reg) && $past(run) |-> $past(miss_cnt_reg) == 2'(MISS_LIMIT - 1))
    else $error("lock dropped without two missed edges");

endmodule

// ### design/ecd_deserializer_top.sv
// six channel deserializer top: pins, spare routing, output drive and control bus
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module ecd_deserializer_top
  import ecd_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // control bus
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // serial link and control pins
  input  wire logic [SER_IN-1:0]            serial_in,
  input  wire logic                         local_reference_clock,
  input  wire logic                         supply_good,
  input  wire logic                         sleep_request_n,
  input  wire logic                         output_drive_enable,
  // parallel side
  output logic [NUM_CH-1:0][WORD_W-1:0]     parallel_word,
  output logic [NUM_CH-1:0]                 parallel_word_oe_n,
  output logic [NUM_CH-1:0]                 recovered_word_strobe,
  output logic [NUM_CH-1:0]                 recovered_word_strobe_oe_n,
  output logic [NUM_CH-1:0]                 sync_loss_flag_n,
  output logic [NUM_CH-1:0]                 sync_loss_flag_oe_n,
  output logic                              spare_channel_monitor,
  output logic                              spare_channel_monitor_oe_n
);

  // ---------------------------------------------------------------
  // pin synchronization
  // ---------------------------------------------------------------
  logic [SER_IN-1:0]  serial_s;
  logic               ref_s;
  logic               supply_s;
  logic               sleep_n_s;
  logic               drive_s;

  ecd_sender_sync_request_b #(
    .W (SER_IN + 4)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({serial_in, local_reference_clock, supply_good, sleep_request_n, output_drive_enable}),
    .q       ({serial_s, ref_s, supply_s, sleep_n_s, drive_s})
  );

  // ---------------------------------------------------------------
  // power state and reference lock
  // ---------------------------------------------------------------
  logic        ref_prev_reg;
  logic        ref_edge;
  logic        awake;
  logic [4:0]  ref_cnt_reg;
  logic        ref_ok_reg;
  logic        run;
  logic [2:0]  spare_sel_reg;

  assign ref_edge = ref_s & ~ref_prev_reg;
  assign awake    = supply_s & sleep_n_s;
  assign run      = awake & ref_ok_reg;

  // reference edge finder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_s;
    end
  end

  // local loop settle count, restarted by any sleep or supply drop
  always_ff @(posedge aclk) begin
    if (!aresetn || !awake) begin
      ref_cnt_reg <= 5'h00;
      ref_ok_reg  <= 1'b0;
    end else if (ref_edge && !ref_ok_reg) begin
      if (ref_cnt_reg == 5'(REF_LOCK_EDGES - 1)) begin
        ref_ok_reg <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // channels with spare substitution
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0][WORD_W-1:0] ch_word;
  logic [NUM_CH-1:0]             ch_locked;
  logic [NUM_CH-1:0]             ch_strobe;
  logic [NUM_CH-1:0]             ch_bit;

  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    // spare input replaces this channel when selected; dead while asleep
    assign ch_bit[k] = awake & ((spare_sel_reg == 3'(k)) ? serial_s[SER_IN-1] : serial_s[k]);

    ecd_channel u_channel (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .run        (run),
      .bit_strobe (ref_edge),
      .serial_bit (ch_bit[k]),
      .word_reg   (ch_word[k]),
      .locked_reg (ch_locked[k]),
      .strobe_reg (ch_strobe[k])
    );

    // output stage: value and drive for word, strobe and flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        parallel_word[k]              <= '0;
        recovered_word_strobe[k]      <= 1'b0;
        sync_loss_flag_n[k]           <= 1'b1;
        parallel_word_oe_n[k]         <= 1'b1;
        recovered_word_strobe_oe_n[k] <= 1'b1;
        sync_loss_flag_oe_n[k]        <= 1'b1;
      end else begin
        parallel_word[k]              <= ch_word[k];
        recovered_word_strobe[k]      <= ch_strobe[k];
        sync_loss_flag_n[k]           <= ~ch_locked[k];
        parallel_word_oe_n[k]         <= ~(awake & drive_s & ch_locked[k]);
        recovered_word_strobe_oe_n[k] <= ~(awake & drive_s & ch_locked[k]);
        sync_loss_flag_oe_n[k]        <= ~awake;
      end
    end

    logic [2:0] strobe_len_reg;

    // bit slots the word strobe has stood high, for the width check
    always_ff @(posedge aclk) begin
      if (!aresetn || !recovered_word_strobe[k]) begin
        strobe_len_reg <= 3'h0;
      end else if (ref_edge) begin
        strobe_len_reg <= strobe_len_reg + 3'h1;
      end
    end

    a_first_word: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(sync_loss_flag_n[k]) |-> $rose(recovered_word_strobe[k]))
      else $error("sync flag fell without a fresh word");
    a_loss_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
      sync_loss_flag_n[k] |-> parallel_word_oe_n[k] && recovered_word_strobe_oe_n[k])
      else $error("outputs driven while sync is lost");
    a_word_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(parallel_word[k]) && !sync_loss_flag_n[k] |-> $rose(recovered_word_strobe[k]))
      else $error("word changed without a strobe rise");
    a_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(recovered_word_strobe[k]) && $past(run, 2) |-> $past(strobe_len_reg) == 3'(STROBE_HIGH))
      else $error("word strobe width is not six bit slots");
  end

  // ---------------------------------------------------------------
  // spare channel monitor
  // ---------------------------------------------------------------
  logic mon_next;

  // displaced input or raw spare, undecoded
  always_comb begin
    mon_next = 1'b0;
    if (spare_sel_reg == SPARE_SEL_RAW) begin
      mon_next = serial_s[SER_IN-1];
    end else if (spare_sel_reg < 3'(NUM_CH)) begin
      mon_next = serial_s[spare_sel_reg];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spare_channel_monitor      <= 1'b0;
      spare_channel_monitor_oe_n <= 1'b1;
    end else begin
      spare_channel_monitor      <= mon_next & awake;
      spare_channel_monitor_oe_n <= ~awake | (spare_sel_reg == SPARE_SEL_OFF);
    end
  end

  // ---------------------------------------------------------------
  // control bus slave
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              commit;
  logic [3:0]        aw_word;
  logic [3:0]        ar_word;
  logic [31:0]       status_word;

  assign commit      = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign aw_word     = {aw_addr_reg[3:2], 2'b00};
  assign ar_word     = {s_axi_araddr[3:2], 2'b00};
  assign status_word = {22'h000000, ref_ok_reg, awake, 2'b00, ch_locked};

  // write address and data are taken independently, then committed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_reg   <= '0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end
      if (commit) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bresp   <= (aw_word == CTRL_OFFSET || aw_word == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // spare route select, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spare_sel_reg <= SPARE_SEL_RESET;
    end else if (commit && aw_word == CTRL_OFFSET && w_strb_reg[0]) begin
      spare_sel_reg <= w_data_reg[SPARE_SEL_LSB +: 3];
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (ar_word == CTRL_OFFSET) begin
        s_axi_rdata <= {29'h00000000, spare_sel_reg};
        s_axi_rresp <= RESP_OKAY;
      end else if (ar_word == STATUS_OFFSET) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks on power, drive and routing
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wake;
    $rose(sleep_n_s) && supply_s;
  endsequence

  sequence s_settling;
    !ref_ok_reg && (ch_locked == '0);
  endsequence

  sequence s_spare_routed;
    (spare_sel_reg < 3'(NUM_CH)) && awake;
  endsequence

  a_reinit_wake: assert property (s_wake |=> s_settling [*2])
    else $error("wake did not restart initialization");
  a_sleep_tristate: assert property (!sleep_n_s |=> (&parallel_word_oe_n) && (&sync_loss_flag_oe_n)
                                     && (&recovered_word_strobe_oe_n) && spare_channel_monitor_oe_n)
    else $error("outputs driven while asleep");
  a_supply_hold: assert property (!supply_s |=> (&sync_loss_flag_oe_n) && !ref_ok_reg && (ch_locked == '0))
    else $error("activity before supply good");
  a_drive_off: assert property (!drive_s |=> (&parallel_word_oe_n) && (&recovered_word_strobe_oe_n))
    else $error("words driven with drive enable low");
  a_flags_kept: assert property (!drive_s && awake |=> sync_loss_flag_oe_n == '0)
    else $error("sync flags released by drive enable");
  a_monitor_off: assert property (spare_sel_reg == SPARE_SEL_OFF |=> spare_channel_monitor_oe_n)
    else $error("monitor driven with select six");
  a_spare_raw: assert property (spare_sel_reg == SPARE_SEL_RAW && awake
                                |=> spare_channel_monitor == $past(serial_s[SER_IN-1]))
    else $error("monitor does not follow spare input");
  a_asleep_quiet: assert property (!awake |=> ch_locked == '0)
    else $error("channel locked while asleep");
  a_monitor_quiet: assert property (!awake |=> !spare_channel_monitor && spare_channel_monitor_oe_n)
    else $error("serial input seen on monitor while asleep");
  a_flags_awake: assert property (awake |=> sync_loss_flag_oe_n == '0)
    else $error("sync flags not driven while awake");
  a_drive_resume: assert property (drive_s && awake |=> parallel_word_oe_n == $past(~ch_locked))
    else $error("word drive does not follow lock with drive enable high");
  a_settle_gate: assert property (!ref_ok_reg |=> ch_locked == '0)
    else $error("channel locked before the reference settled");
  a_spare_route: assert property (s_spare_routed |=> !spare_channel_monitor_oe_n
                                  && spare_channel_monitor == $past(serial_s[spare_sel_reg]))
    else $error("monitor does not show the displaced input");

endmodule

// ### sim/ecd_serializer_model.sv
// behavioural serializer model driving one framed serial lane
`timescale 1ns/10ps
module ecd_serializer_model
  import ecd_pkg::*;
#(
  parameter logic [WORD_W-1:0] TRAIN_WORD = 10'h01F
) (
  input  wire logic              bit_clock,
  input  wire logic              sync_request,
  input  wire logic              break_stop,
  output logic                   serial_out,
  output logic                   frame_tick,
  output logic      [WORD_W-1:0] sent_word
);
  logic [WORD_W-1:0] cur_word = '0;
  int                slot     = 0;
  initial serial_out = 1'b0;
  initial frame_tick = 1'b0;
  initial sent_word = '0;
  // one slot per falling edge: start, ten data bits, stop, frames back to back
  always @(negedge bit_clock) begin
    if (slot == 0) begin
      cur_word = (sync_request === 1'b1) ? TRAIN_WORD : WORD_W'($urandom);
      serial_out <= 1'b1;
      frame_tick <= 1'b1;
    end else if (slot == FRAME_BITS - 1) begin
      serial_out <= break_stop;
      sent_word <= cur_word;
    end else begin
      serial_out <= cur_word[slot-1];
      frame_tick <= 1'b0;
    end
    slot = (slot + 1) % FRAME_BITS;
  end
endmodule

// ### sim/tb_ecd_deserializer_top.sv
// self-checking bench for the six channel deserializer top
`timescale 1ns/10ps
module tb_ecd_deserializer_top
  import ecd_pkg::*;
;
  logic aclk = 0, aresetn = 0, ref_clk = 0, supply_good = 0, sleep_n = 1, drive_en = 1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, mon, mon_oe_n;
  logic [1:0] bresp, rresp;
  logic [NUM_CH-1:0][WORD_W-1:0] pw;
  logic [NUM_CH-1:0] pw_oe_n, strb, strb_oe_n, flag_n, flag_oe_n;
  logic [NUM_CH-1:0] prev_f = '1, prev_s = '0;
  logic [SER_IN-1:0] ser, tick, brk = '0;
  logic [SER_IN-1:0][WORD_W-1:0] sent;
  wire logic [SER_IN-1:0] sreq = {1'b0, flag_n};
  int n_mismatch = 0, checks = 0, cyc = 0, nfr = 0, sel = 6;
  bit cmp_en = 1;

  always #2.5 aclk = ~aclk;
  // free-running reference shared by both link ends
  initial begin
    #3.1;
    forever #24 ref_clk = ~ref_clk;
  end
  always @(posedge tick[0]) nfr++;

  ecd_deserializer_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in(ser), .local_reference_clock(ref_clk),
    .supply_good(supply_good), .sleep_request_n(sleep_n), .output_drive_enable(drive_en), .parallel_word(pw),
    .parallel_word_oe_n(pw_oe_n), .recovered_word_strobe(strb), .recovered_word_strobe_oe_n(strb_oe_n),
    .sync_loss_flag_n(flag_n), .sync_loss_flag_oe_n(flag_oe_n), .spare_channel_monitor(mon),
    .spare_channel_monitor_oe_n(mon_oe_n));
  // one serializer per serial input, lock flag fed back as sync request
  for (genvar k = 0; k < SER_IN; k++) begin : g_lane
    ecd_serializer_model lane_u (.bit_clock(ref_clk), .sync_request(sreq[k]), .break_stop(brk[k]),
      .serial_out(ser[k]), .frame_tick(tick[k]), .sent_word(sent[k]));
  end

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: bus %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_reg(bresp, r);
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_reg(rdata, d);
    chk_reg(rresp, r);
  endtask
  task automatic wait_frames(input int k, input int n);
    repeat (n) @(posedge tick[k]);
  endtask
  task automatic wait_lock();
    while (flag_n !== '0) @(posedge aclk);
  endtask

  // watchdog and per-cycle model comparison of every channel
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (aresetn && prev_f[c] && flag_n[c] === 1'b0) chk_pin({strb[c], pw_oe_n[c]}, 2'b10);
      if (cmp_en && flag_n[c] === 1'b0 && !prev_s[c] && strb[c] === 1'b1)
        chk_pin(pw[c], sent[(sel == c) ? SER_IN - 1 : c]);
      if (flag_n[c] === 1'b1) chk_pin({pw_oe_n[c], strb_oe_n[c]}, 2'b11);
    end
    prev_f <= flag_n;
    prev_s <= strb;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    void'($urandom(88));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (200) @(posedge aclk);
    chk_pin({pw_oe_n, strb_oe_n, flag_oe_n, mon_oe_n}, 19'h7FFFF);
    axi_rd(CTRL_OFFSET, 32'(SPARE_SEL_RESET), RESP_OKAY);
    axi_rd(4'h8, 32'h0, RESP_SLVERR);
    axi_wr(4'hC, 32'h7, RESP_SLVERR);
    supply_good <= 1'b1;
    nfr = 0;
    wait_lock();
    chk_pin(32'(nfr >= SYNC_FRAMES), 1);
    wait_frames(0, 20);
    axi_rd(STATUS_OFFSET, 32'h0000033F, RESP_OKAY);
    // one broken stop bit keeps lock, two in a row drop it
    @(posedge tick[2]) brk[2] = 1'b1;
    @(posedge tick[2]) brk[2] = 1'b0;
    wait_frames(2, 2);
    chk_pin(flag_n, 6'h00);
    @(posedge tick[2]) brk[2] = 1'b1;
    wait_frames(2, 2);
    brk[2] = 1'b0;
    wait_frames(2, 1);
    chk_pin(flag_n, 6'h04);
    wait_lock();
    drive_en <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_pin({pw_oe_n, strb_oe_n, flag_oe_n, flag_n}, 24'hFFF000);
    drive_en <= 1'b1;
    repeat (8) @(posedge aclk);
    chk_pin({pw_oe_n, strb_oe_n}, 12'h000);
    // walk every spare select code, then leave the spare on channel 3
    cmp_en = 0;
    for (int k = 0; k < 9; k++) begin
      axi_wr(CTRL_OFFSET, (k == 8) ? 3 : k, RESP_OKAY);
      sel = (k == 8) ? 3 : k;
      repeat (2) @(posedge ref_clk);
      chk_pin(mon_oe_n, sel == 6);
      for (int i = 0; i < 4 && sel != 6; i++) @(posedge ref_clk) chk_pin(mon, ser[sel == 7 ? 6 : sel]);
    end
    wait_frames(6, 3);
    cmp_en = 1;
    wait_frames(6, 10);
    @(posedge aclk);
    sleep_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_pin({pw_oe_n, strb_oe_n, flag_oe_n, mon_oe_n}, 19'h7FFFF);
    sleep_n <= 1'b1;
    repeat (20) @(posedge aclk);
    chk_pin(flag_n, 6'h3F);
    wait_lock();
    wait_frames(0, 5);
    give_verdict();
  end
endmodule
